// ### inc/dsrc_pkg.sv
package dsrc_pkg;
	// data-rate codes held in the rate register
	localparam logic [1:0] DSRC_RATE_500K = 2'h0;
	localparam logic [1:0] DSRC_RATE_300K = 2'h1;
	localparam logic [1:0] DSRC_RATE_250K = 2'h2;
	localparam logic [1:0] DSRC_RATE_1M = 2'h3;
	localparam logic [1:0] DSRC_RATE_RESET = DSRC_RATE_250K;
	// core prescaler divide codes (24 MHz / n)
	localparam logic [2:0] DSRC_CORE_DIV3 = 3'h3;
	localparam logic [2:0] DSRC_CORE_DIV5 = 3'h5;
	localparam logic [2:0] DSRC_CORE_DIV6 = 3'h6;
	// vco divide factors
	localparam logic [4:0] DSRC_VCO_DIV4 = 5'h04;
	localparam logic [4:0] DSRC_VCO_DIV8 = 5'h08;
	localparam logic [4:0] DSRC_VCO_DIV16 = 5'h10;
	// apb register map
	localparam int DSRC_ADDR_W = 8;
	localparam logic [7:0] DSRC_OFS_DATA = 8'h00;
	localparam logic [7:0] DSRC_OFS_STATUS = 8'h04;
	localparam logic [7:0] DSRC_OFS_RATE = 8'h08;
	localparam logic [7:0] DSRC_OFS_MODE = 8'h0c;
	localparam logic [7:0] DSRC_OFS_SEP = 8'h10;
	// main status bits
	localparam int DSRC_MSR_RQM = 7;
	localparam int DSRC_MSR_DIO = 6;
	localparam int DSRC_MSR_BUSY = 4;
	// mode register bits
	localparam int DSRC_MODE_PU = 0;
	localparam int DSRC_MODE_RG = 1;
	localparam int DSRC_MODE_RDEN = 2;
	localparam logic [2:0] DSRC_MODE_RESET = 3'h0;
	// separator status bits
	localparam int DSRC_SEP_LOCKED = 0;
	localparam int DSRC_SEP_SEARCH = 1;
	localparam int DSRC_SEP_OVR = 2;
	localparam int DSRC_SEP_TRIM_LO = 4;
	// timing: half bit cell per rate at the system clock
	localparam int DSRC_CLK_MHZ = 20;
	localparam int DSRC_HALF_1M_NS = 500;
	localparam int DSRC_HALF_500K_NS = 1000;
	localparam int DSRC_HALF_300K_NS = 1667;
	localparam int DSRC_HALF_250K_NS = 2000;
	localparam logic [7:0] DSRC_HALF_1M_CYC = 8'(DSRC_HALF_1M_NS * DSRC_CLK_MHZ / 1000);
	localparam logic [7:0] DSRC_HALF_500K_CYC = 8'(DSRC_HALF_500K_NS * DSRC_CLK_MHZ / 1000);
	localparam logic [7:0] DSRC_HALF_300K_CYC = 8'(DSRC_HALF_300K_NS * DSRC_CLK_MHZ / 1000);
	localparam logic [7:0] DSRC_HALF_250K_CYC = 8'(DSRC_HALF_250K_NS * DSRC_CLK_MHZ / 1000);
	// lock must come within half of the preamble
	localparam int DSRC_PREAMBLE_BYTES = 12;
	localparam logic [7:0] DSRC_LOCK_CELLS = 8'(DSRC_PREAMBLE_BYTES * 8 / 2);
	// cell-period trim of the secondary loop
	localparam logic [2:0] DSRC_TRIM_MID = 3'h4;
	localparam logic [2:0] DSRC_TRIM_MAX = 3'h7;
	localparam logic [2:0] DSRC_TRIM_MIN = 3'h0;
	localparam logic [2:0] DSRC_BIT_LAST = 3'h7;

	typedef struct packed {
		logic filt_hi;
		logic filt_lo;
		logic [2:0] core_div;
		logic [4:0] vco_div;
		logic vco_48;
		logic [7:0] half_cyc;
	} dsrc_rate_cfg_t;

	typedef enum logic [1:0] {
		DSRC_ST_IDLE = 2'b00,
		DSRC_ST_SEARCH = 2'b01,
		DSRC_ST_LOCKED = 2'b10
	} dsrc_state_t;
endpackage : dsrc_pkg

// ### logic/dsrc_top.sv
// How it works
// - core clock prescaler picks 4, 4.8 or 8 MHz from the rate setting
// - commands in and results out one byte at a time, paced by status flags
// - 500 kb/s enables high-rate filter switch, low-rate switch off
// - 250 or 300 kb/s enables low-rate switch, high-rate switch off
// - 1 Mb/s turns both filter switches off
// - vco divide is 4 at 1M, 8 at 500k, 16 at 300k and 250k
// - vco centre is 4 MHz except 4.8 MHz at 300 kb/s
// - non-preamble pattern during id search forces relock to reference
// - pump output and external read gate enabled by mode bits
// - pump enabled: shared pin shows charge pump corrections
// - external read gate starts the id search for lock to data, or forces back to reference
// - quarter-period centring with secondary loop trimming the cell period
// - split clock and data pulses, assemble data bits into bytes
// - lock declared within half the twelve-byte preamble
// - speed-type low with 300 kb/s runs everything at 250 kb/s
// - pump enable turns pin to output and forces scaled precomp
// - reset sets the rate to 250 kb/s
`timescale 1ns/1ps
module dsrc_top (
	input wire logic clk_sys, // 20 MHz system clock
	input wire logic reset, // synchronous, active high
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [dsrc_pkg::DSRC_ADDR_W-1:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic rdata_n, // raw read data, active low
	input wire logic drive_speed_type, // high: true 300 kb/s
	input wire logic ext_read_gate, // external read gate
	input wire logic pump_up, // charge pump raising correction
	input wire logic pump_dn, // charge pump lowering correction
	input wire logic pump_or_precomp_pin_i, // shared pin level
	output logic pump_or_precomp_pin_o, // shared pin drive value
	output logic pump_or_precomp_pin_oe, // shared pin drive enable
	output logic precomp_scaled, // precomp mode seen by write logic
	output logic filter_sw_high_rate, // high-rate filter ground switch on
	output logic filter_sw_low_rate, // low-rate filter ground switch on
	output logic [2:0] core_clk_div, // core prescaler divide
	output logic [4:0] vco_div, // vco divide factor
	output logic vco_center_48, // vco centre 4.8 MHz when high
	output logic pll_ref_lock, // pll locked to reference clock
	output logic pll_relock, // one-cycle relock pulse
	output logic [7:0] cmd_byte, // command byte to core
	output logic cmd_valid, // one-cycle command strobe
	input wire logic cmd_taken, // core consumed the command
	input wire logic [7:0] res_byte, // result byte from core
	input wire logic res_valid, // result byte strobe
	output logic res_ready // result path may accept
);
	import dsrc_pkg::*;

	logic pready_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic [1:0] rate_r;
	logic [2:0] mode_r;
	logic [1:0] eff_rate;
	dsrc_rate_cfg_t cfg_nxt;
	dsrc_rate_cfg_t cfg_r;
	logic pump_o_r;
	logic pump_oe_r;
	logic precomp_r;
	logic rdata_d_r;
	logic rd_pulse;
	logic read_gate;
	dsrc_state_t state_r;
	logic [7:0] phase_r;
	logic [7:0] period;
	logic [7:0] centre;
	logic wrap;
	logic slot_r;
	logic seen_r;
	logic [7:0] lock_cnt_r;
	logic [2:0] trim_r;
	logic framed_r;
	logic [2:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic sep_done;
	logic [7:0] sep_byte;
	logic relock_r;
	logic [7:0] rx_byte_r;
	logic rx_full_r;
	logic rx_full_nxt;
	logic res_take;
	logic ovr_r;
	logic [7:0] cmd_byte_r;
	logic cmd_valid_r;
	logic cmd_busy_r;
	logic res_ready_r;
	logic wr_go;
	logic rd_go;
	logic [31:0] rd_mux;
	logic rd_err;

	// apb: one wait state, answer registered on the second access cycle
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pready_r <= 1'b0;
		end else begin
			pready_r <= psel & penable & ~pready_r;
		end
	end

	assign wr_go = psel & penable & pready_r & pwrite;
	assign rd_go = psel & penable & pready_r & ~pwrite;

	// read mux and decode; unmapped reads give zero and an error
	always_comb begin
		rd_mux = 32'h0;
		rd_err = 1'b0;
		case (paddr)
			DSRC_OFS_DATA: rd_mux[7:0] = rx_byte_r;
			DSRC_OFS_STATUS: begin
				rd_mux[DSRC_MSR_RQM] = rx_full_r | ~cmd_busy_r;
				rd_mux[DSRC_MSR_DIO] = rx_full_r;
				rd_mux[DSRC_MSR_BUSY] = cmd_busy_r;
			end
			DSRC_OFS_RATE: rd_mux[1:0] = rate_r;
			DSRC_OFS_MODE: rd_mux[2:0] = mode_r;
			DSRC_OFS_SEP: begin
				rd_mux[DSRC_SEP_LOCKED] = (state_r == DSRC_ST_LOCKED);
				rd_mux[DSRC_SEP_SEARCH] = (state_r == DSRC_ST_SEARCH);
				rd_mux[DSRC_SEP_OVR] = ovr_r;
				rd_mux[DSRC_SEP_TRIM_LO +: 3] = trim_r;
			end
			default: rd_err = 1'b1;
		endcase
	end

	// read data and error captured one cycle before ready
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			prdata_r <= 32'h0;
			pslverr_r <= 1'b0;
		end else if (psel & penable & ~pready_r) begin
			prdata_r <= rd_mux;
			pslverr_r <= rd_err;
		end else begin
			pslverr_r <= 1'b0;
		end
	end

	// rate and mode registers
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rate_r <= DSRC_RATE_RESET;
			mode_r <= DSRC_MODE_RESET;
		end else if (wr_go) begin
			if (paddr == DSRC_OFS_RATE) begin
				rate_r <= pwdata[1:0];
			end
			if (paddr == DSRC_OFS_MODE) begin
				mode_r <= pwdata[2:0];
			end
		end
	end

	// dual-speed drives run the 300 setting at 250
	assign eff_rate = (rate_r == DSRC_RATE_300K && !drive_speed_type) ?
		DSRC_RATE_250K : rate_r;

	// rate decode; fm rates are not distinguished here
	always_comb begin
		cfg_nxt = '0;
		case (eff_rate)
			DSRC_RATE_500K: begin
				cfg_nxt.filt_hi = 1'b1;
				cfg_nxt.filt_lo = 1'b0;
				cfg_nxt.core_div = DSRC_CORE_DIV3;
				cfg_nxt.vco_div = DSRC_VCO_DIV8;
				cfg_nxt.vco_48 = 1'b0;
				cfg_nxt.half_cyc = DSRC_HALF_500K_CYC;
			end
			DSRC_RATE_300K: begin
				cfg_nxt.filt_hi = 1'b0;
				cfg_nxt.filt_lo = 1'b1;
				cfg_nxt.core_div = DSRC_CORE_DIV5;
				cfg_nxt.vco_div = DSRC_VCO_DIV16;
				cfg_nxt.vco_48 = 1'b1;
				cfg_nxt.half_cyc = DSRC_HALF_300K_CYC;
			end
			DSRC_RATE_1M: begin
				cfg_nxt.filt_hi = 1'b0;
				cfg_nxt.filt_lo = 1'b0;
				cfg_nxt.core_div = DSRC_CORE_DIV3;
				cfg_nxt.vco_div = DSRC_VCO_DIV4;
				cfg_nxt.vco_48 = 1'b0;
				cfg_nxt.half_cyc = DSRC_HALF_1M_CYC;
			end
			default: begin
				cfg_nxt.filt_hi = 1'b0;
				cfg_nxt.filt_lo = 1'b1;
				cfg_nxt.core_div = DSRC_CORE_DIV6;
				cfg_nxt.vco_div = DSRC_VCO_DIV16;
				cfg_nxt.vco_48 = 1'b0;
				cfg_nxt.half_cyc = DSRC_HALF_250K_CYC;
			end
		endcase
	end

	// one register for all rate outputs, so no mixed combination appears
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cfg_r <= '0;
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	// shared pump / precomp pin
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pump_o_r <= 1'b0;
			pump_oe_r <= 1'b0;
			precomp_r <= 1'b0;
		end else begin
			pump_oe_r <= mode_r[DSRC_MODE_PU];
			pump_o_r <= mode_r[DSRC_MODE_PU] & (pump_up | pump_dn);
			precomp_r <= mode_r[DSRC_MODE_PU] | pump_or_precomp_pin_i;
		end
	end

	// falling edge of raw data marks a flux pulse
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rdata_d_r <= 1'b1;
		end else begin
			rdata_d_r <= rdata_n;
		end
	end

	assign rd_pulse = rdata_d_r & ~rdata_n;
	assign read_gate = mode_r[DSRC_MODE_RG] ? ext_read_gate : mode_r[DSRC_MODE_RDEN];
	// trimmed half-cell; centre sits a quarter bit cell
	assign period = cfg_r.half_cyc + 8'(trim_r) - 8'(DSRC_TRIM_MID);
	assign centre = {1'b0, period[7:1]};
	assign wrap = (phase_r >= period - 8'h01);

	// cell timer: a pulse re-centres the phase, wrap flips clock/data slot
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			phase_r <= 8'h00;
			slot_r <= 1'b0;
			seen_r <= 1'b0;
		end else if (state_r == DSRC_ST_IDLE) begin
			phase_r <= 8'h00;
			slot_r <= 1'b0;
			seen_r <= 1'b0;
		end else if (rd_pulse) begin
			phase_r <= centre;
			seen_r <= slot_r;
			if (state_r == DSRC_ST_SEARCH && slot_r) begin
				slot_r <= 1'b0; // realign on relock
			end
		end else if (wrap) begin
			phase_r <= 8'h00;
			slot_r <= ~slot_r;
			if (slot_r) begin
				seen_r <= 1'b0;
			end
		end else begin
			phase_r <= phase_r + 8'h01;
		end
	end

	// secondary loop: early pulses shorten the cell, late ones lengthen it
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			trim_r <= DSRC_TRIM_MID;
		end else if (rd_pulse && state_r == DSRC_ST_LOCKED) begin
			if (phase_r < centre && trim_r != DSRC_TRIM_MIN) begin
				trim_r <= trim_r - 3'h1;
			end else if (phase_r > centre && trim_r != DSRC_TRIM_MAX) begin
				trim_r <= trim_r + 3'h1;
			end
		end
	end

	// id search: count preamble clock pulses, relock on anything else
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_r <= DSRC_ST_IDLE;
			lock_cnt_r <= 8'h00;
			relock_r <= 1'b0;
		end else begin
			relock_r <= 1'b0;
			case (state_r)
				DSRC_ST_IDLE: begin
					lock_cnt_r <= 8'h00;
					if (read_gate) begin
						state_r <= DSRC_ST_SEARCH;
					end
				end
				DSRC_ST_SEARCH: begin
					if (!read_gate) begin
						state_r <= DSRC_ST_IDLE;
					end else if (rd_pulse && slot_r) begin
						lock_cnt_r <= 8'h00;
						relock_r <= 1'b1;
					end else if (rd_pulse) begin
						if (lock_cnt_r == DSRC_LOCK_CELLS - 8'h01) begin
							state_r <= DSRC_ST_LOCKED;
						end
						lock_cnt_r <= lock_cnt_r + 8'h01;
					end
				end
				DSRC_ST_LOCKED: begin
					if (!read_gate) begin
						state_r <= DSRC_ST_IDLE;
						relock_r <= 1'b1;
					end
				end
				default: state_r <= DSRC_ST_IDLE;
			endcase
		end
	end

	// deserialiser: first data one after lock frames the byte stream
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			framed_r <= 1'b0;
			bit_cnt_r <= 3'h0;
			shift_r <= 8'h00;
		end else if (state_r != DSRC_ST_LOCKED) begin
			framed_r <= 1'b0;
			bit_cnt_r <= 3'h0;
		end else if (wrap && slot_r && (framed_r || seen_r)) begin
			framed_r <= 1'b1;
			shift_r <= {shift_r[6:0], seen_r};
			bit_cnt_r <= bit_cnt_r + 3'h1;
		end
	end

	assign sep_done = (state_r == DSRC_ST_LOCKED) && wrap && slot_r &&
		(framed_r || seen_r) && (bit_cnt_r == DSRC_BIT_LAST);
	assign sep_byte = {shift_r[6:0], seen_r};
	assign res_take = res_valid & ~rx_full_r & ~sep_done;

	// byte toward the host; a new byte wins over the read that clears it
	always_comb begin
		rx_full_nxt = rx_full_r;
		if (rd_go && paddr == DSRC_OFS_DATA) begin
			rx_full_nxt = 1'b0;
		end
		if (sep_done || res_take) begin
			rx_full_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rx_byte_r <= 8'h00;
			rx_full_r <= 1'b0;
			res_ready_r <= 1'b0;
		end else begin
			rx_full_r <= rx_full_nxt;
			res_ready_r <= ~rx_full_nxt;
			if (sep_done) begin
				rx_byte_r <= sep_byte;
			end else if (res_take) begin
				rx_byte_r <= res_byte;
			end
		end
	end

	// overrun: a new separator byte overwrote the previous one while it was unread
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ovr_r <= 1'b0;
		end else if (sep_done && rx_full_r && !(rd_go && paddr == DSRC_OFS_DATA)) begin
			ovr_r <= 1'b1;
		end else if (rd_go && paddr == DSRC_OFS_SEP) begin
			ovr_r <= 1'b0;
		end
	end

	// command byte; refused while busy or while a byte waits for the host
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cmd_byte_r <= 8'h00;
			cmd_valid_r <= 1'b0;
			cmd_busy_r <= 1'b0;
		end else begin
			cmd_valid_r <= 1'b0;
			if (wr_go && paddr == DSRC_OFS_DATA && !cmd_busy_r && !rx_full_r) begin
				cmd_byte_r <= pwdata[7:0];
				cmd_valid_r <= 1'b1;
				cmd_busy_r <= 1'b1;
			end else if (cmd_taken) begin
				cmd_busy_r <= 1'b0;
			end
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign pump_or_precomp_pin_o = pump_o_r;
	assign pump_or_precomp_pin_oe = pump_oe_r;
	assign precomp_scaled = precomp_r;
	assign filter_sw_high_rate = cfg_r.filt_hi;
	assign filter_sw_low_rate = cfg_r.filt_lo;
	assign core_clk_div = cfg_r.core_div;
	assign vco_div = cfg_r.vco_div;
	assign vco_center_48 = cfg_r.vco_48;
	assign pll_ref_lock = (state_r != DSRC_ST_LOCKED);
	assign pll_relock = relock_r;
	assign cmd_byte = cmd_byte_r;
	assign cmd_valid = cmd_valid_r;
	assign res_ready = res_ready_r;
endmodule : dsrc_top

// ### test/dsrc_checker.sv
`timescale 1ns/1ps
module dsrc_checker (
	input wire logic clk_sys, // system clock
	input wire logic reset, // sync reset
	input wire logic psel, // apb select
	input wire logic penable, // apb access
	input wire logic pready, // apb ready
	input wire logic pump_up, // pump raise
	input wire logic pump_dn, // pump lower
	input wire logic pump_or_precomp_pin_i, // pin level
	input wire logic pump_or_precomp_pin_o, // pin drive
	input wire logic pump_or_precomp_pin_oe, // pin enable
	input wire logic precomp_scaled, // precomp mode
	input wire logic filter_sw_high_rate, // high filter
	input wire logic filter_sw_low_rate, // low filter
	input wire logic [2:0] core_clk_div, // prescaler
	input wire logic [4:0] vco_div, // vco divide
	input wire logic vco_center_48, // 4.8 MHz centre
	input wire logic cmd_valid // command strobe
);
	import dsrc_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	// one wait state, then ready for a single cycle
	sequence acc_s;
		!pready ##1 pready ##1 !pready;
	endsequence
	apb_wait_a: assert property (psel && !penable |=> acc_s)
		else $error("apb answer not after exactly one wait state");
	// rate outputs must always form a legal set, never a mix of two rates
	hi_rate_cfg_a: assert property (
		filter_sw_high_rate |-> !filter_sw_low_rate && vco_div == DSRC_VCO_DIV8
		&& core_clk_div == DSRC_CORE_DIV3) else $error("500k set inconsistent");
	lo_rate_cfg_a: assert property (
		filter_sw_low_rate |-> !filter_sw_high_rate && vco_div == DSRC_VCO_DIV16)
		else $error("low-rate switch with wrong divider");
	one_meg_cfg_a: assert property (
		!filter_sw_high_rate && !filter_sw_low_rate && !$past(reset)
		|-> vco_div == DSRC_VCO_DIV4 && core_clk_div == DSRC_CORE_DIV3)
		else $error("both switches off without 1M set");
	vco_center_a: assert property (
		vco_center_48 |-> core_clk_div == DSRC_CORE_DIV5 && vco_div == DSRC_VCO_DIV16)
		else $error("4.8 MHz centre with wrong prescaler");
	reset_rate_a: assert property ($fell(reset) |=> filter_sw_low_rate
		&& core_clk_div == DSRC_CORE_DIV6 && vco_div == DSRC_VCO_DIV16)
		else $error("rate after reset not 250k");
	pump_pin_a: assert property (
		pump_or_precomp_pin_oe |-> pump_or_precomp_pin_o == $past(pump_up || pump_dn))
		else $error("pump pin does not follow corrections");
	precomp_sel_a: assert property (!$past(reset) |->
		(pump_or_precomp_pin_oe ? precomp_scaled : precomp_scaled == $past(pump_or_precomp_pin_i)))
		else $error("precomp mode wrong for pin use");
	cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid)
		else $error("command strobe longer than one cycle");
endmodule : dsrc_checker

bind dsrc_top dsrc_checker dsrc_checker_i (.clk_sys, .reset, .psel, .penable, .pready,
	.pump_up, .pump_dn, .pump_or_precomp_pin_i, .pump_or_precomp_pin_o,
	.pump_or_precomp_pin_oe, .precomp_scaled, .filter_sw_high_rate, .filter_sw_low_rate,
	.core_clk_div, .vco_div, .vco_center_48, .cmd_valid);

// ### test/dsrc_drive_model.sv
`timescale 1ns/1ps
module dsrc_drive_model (
	input wire logic clk_sys, // system clock
	input wire logic spin, // media turning under the head
	input wire logic ones, // high: data-slot pulses, low: clock-slot pulses
	input wire logic [7:0] half, // half bit cell in clocks
	output logic rdata_n // raw flux, active low
);
	logic [8:0] cnt_r;
	logic ones_r;
	logic pulse_r = 1'b0;
	// only mfm cells are made; fm filters would need their own selection
	// line idles high as the cable pull-up leaves it
	assign rdata_n = !pulse_r;
	// cell counter; pattern switches only at a cell edge so no short cell appears
	always_ff @(posedge clk_sys) begin
		cnt_r <= (!spin || cnt_r + 9'h001 == {half, 1'b0}) ? 9'h000 : cnt_r + 9'h001;
		if (cnt_r == 9'h000)
			ones_r <= ones;
		pulse_r <= spin && cnt_r == (ones_r ? {1'b0, half} : 9'h000);
	end
endmodule : dsrc_drive_model

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench;
	import dsrc_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, rdata_n, pump_or_precomp_pin_o, pump_or_precomp_pin_oe;
	logic drive_speed_type = 1'b1;
	logic ext_read_gate = 1'b0;
	logic pump_up = 1'b0;
	logic pump_dn = 1'b0;
	logic pin_drv = 1'b0;
	logic cmd_taken = 1'b0;
	logic res_valid = 1'b0;
	logic [7:0] res_byte = 8'h00;
	logic spin = 1'b0;
	logic ones = 1'b0;
	logic precomp_scaled, filter_sw_high_rate, filter_sw_low_rate, vco_center_48;
	logic pll_ref_lock, pll_relock, cmd_valid, res_ready;
	logic [2:0] core_clk_div;
	logic [4:0] vco_div;
	logic [7:0] cmd_byte, last_cmd;
	logic [31:0] rd_q;
	logic last_err;
	int err_count = 0;
	int num_checks = 0;
	int cmds = 0;
	int relocks = 0;
	int n, m, r0;
	wire logic pump_or_precomp_pin_i;
	wire logic [31:0] cfg_now = {21'h0, filter_sw_high_rate, filter_sw_low_rate,
		core_clk_div, vco_div, vco_center_48};
	// shared pin: our side lets go while the design drives it
	assign pump_or_precomp_pin_i = pump_or_precomp_pin_oe ? pump_or_precomp_pin_o : pin_drv;

	dsrc_top dsrc_top_i (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .rdata_n, .drive_speed_type, .ext_read_gate, .pump_up,
		.pump_dn, .pump_or_precomp_pin_i, .pump_or_precomp_pin_o, .pump_or_precomp_pin_oe,
		.precomp_scaled, .filter_sw_high_rate, .filter_sw_low_rate, .core_clk_div, .vco_div,
		.vco_center_48, .pll_ref_lock, .pll_relock, .cmd_byte, .cmd_valid, .cmd_taken,
		.res_byte, .res_valid, .res_ready);
	dsrc_drive_model dsrc_drive_model_i (.clk_sys, .spin, .ones, .half(DSRC_HALF_1M_CYC),
		.rdata_n);

	always #25 clk_sys = ~clk_sys;
	// count strobes the core side would see
	always @(posedge clk_sys) begin
		if (pll_relock === 1'b1)
			relocks++;
		if (cmd_valid === 1'b1) begin
			cmds++;
			last_cmd = cmd_byte;
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize

	// wide enough for a counter, a byte and a register word compared at once
	task automatic chk(input logic [79:0] got, input logic [79:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic tmo(input int lim);
		if (n >= lim) begin
			err_count++;
			summarize();
		end
	endtask : tmo

	// one apb transfer; request held until ready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd_q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		tmo(20);
	endtask : apb

	function automatic logic [31:0] cfg_exp(input logic [1:0] r);
		case (r)
			DSRC_RATE_500K: return {21'h0, 2'b10, DSRC_CORE_DIV3, DSRC_VCO_DIV8, 1'b0};
			DSRC_RATE_300K: return {21'h0, 2'b01, DSRC_CORE_DIV5, DSRC_VCO_DIV16, 1'b1};
			DSRC_RATE_250K: return {21'h0, 2'b01, DSRC_CORE_DIV6, DSRC_VCO_DIV16, 1'b0};
			default: return {21'h0, 2'b00, DSRC_CORE_DIV3, DSRC_VCO_DIV4, 1'b0};
		endcase
	endfunction : cfg_exp

	initial begin
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk(cfg_now, cfg_exp(DSRC_RATE_RESET));
		apb(1'b0, DSRC_OFS_RATE, 32'h0);
		chk(rd_q, 32'(DSRC_RATE_RESET));
		$display("test reset done");
		// every rate code, then 300k on a dual-speed drive
		for (int i = 0; i < 5; i++) begin
			if (i == 4)
				drive_speed_type <= 1'b0;
			apb(1'b1, DSRC_OFS_RATE, 32'(i == 4 ? DSRC_RATE_300K : 2'(i)));
			repeat (3) @(posedge clk_sys);
			chk(cfg_now, cfg_exp(i == 4 ? DSRC_RATE_250K : 2'(i)));
			apb(1'b0, DSRC_OFS_RATE, 32'h0);
			chk(rd_q, 32'(i == 4 ? DSRC_RATE_300K : 2'(i)));
		end
		apb(1'b0, 8'h14, 32'h0);
		chk({last_err, rd_q}, {1'b1, 32'h0});
		$display("test rates done");
		// command in, busy refusal, result out
		apb(1'b0, DSRC_OFS_STATUS, 32'h0);
		chk(rd_q, 32'h1 << DSRC_MSR_RQM);
		apb(1'b1, DSRC_OFS_DATA, 32'h5a);
		apb(1'b0, DSRC_OFS_STATUS, 32'h0);
		chk({cmds, last_cmd, rd_q}, {32'd1, 8'h5a, 32'h1 << DSRC_MSR_BUSY});
		apb(1'b1, DSRC_OFS_DATA, 32'h33);
		repeat (2) @(posedge clk_sys);
		chk(cmds, 32'd1);
		cmd_taken <= 1'b1;
		@(posedge clk_sys);
		cmd_taken <= 1'b0;
		res_byte <= 8'h3c;
		res_valid <= 1'b1;
		@(posedge clk_sys);
		res_valid <= 1'b0;
		apb(1'b0, DSRC_OFS_STATUS, 32'h0);
		chk(rd_q, (32'h1 << DSRC_MSR_RQM) | (32'h1 << DSRC_MSR_DIO));
		apb(1'b0, DSRC_OFS_DATA, 32'h0);
		chk(rd_q, 32'h3c);
		apb(1'b0, DSRC_OFS_STATUS, 32'h0);
		chk({res_ready, rd_q}, {1'b1, 32'h1 << DSRC_MSR_RQM});
		$display("test handshake done");
		// pump output on the shared pin, then pin back as precomp input
		apb(1'b1, DSRC_OFS_MODE, 32'h1 << DSRC_MODE_PU);
		for (int i = 0; i < 4; i++) begin
			pump_up <= i[0];
			pump_dn <= i[1];
			repeat (2) @(posedge clk_sys);
			chk({pump_or_precomp_pin_oe, pump_or_precomp_pin_o, precomp_scaled},
				{1'b1, i != 0, 1'b1});
		end
		pump_up <= 1'b0;
		pump_dn <= 1'b0;
		apb(1'b1, DSRC_OFS_MODE, 32'h0);
		for (int i = 0; i < 2; i++) begin
			pin_drv <= i[0];
			repeat (3) @(posedge clk_sys);
			chk({pump_or_precomp_pin_oe, precomp_scaled}, {1'b0, i[0]});
		end
		$display("test pump done");
		// separator at 1M under external read gate
		apb(1'b1, DSRC_OFS_RATE, 32'(DSRC_RATE_1M));
		apb(1'b1, DSRC_OFS_MODE, 32'h1 << DSRC_MODE_RG);
		r0 = relocks;
		ones <= 1'b1;
		spin <= 1'b1;
		ext_read_gate <= 1'b1;
		for (n = 0; n < 300 && relocks == r0; n++)
			@(posedge clk_sys);
		tmo(300);
		chk(pll_ref_lock, 32'h1);
		ext_read_gate <= 1'b0;
		spin <= 1'b0;
		ones <= 1'b0;
		repeat (5) @(posedge clk_sys);
		spin <= 1'b1;
		ext_read_gate <= 1'b1;
		for (n = 0; n < 1500 && pll_ref_lock !== 1'b0; n++)
			@(posedge clk_sys);
		tmo(1500);
		apb(1'b0, DSRC_OFS_SEP, 32'h0);
		chk(rd_q[DSRC_SEP_LOCKED], 32'h1);
		ones <= 1'b1;
		// separator word holds trim in bit 6, so start the poll from a clean word
		rd_q = 32'h0;
		for (m = 0; m < 100 && rd_q[DSRC_MSR_DIO] !== 1'b1; m++)
			apb(1'b0, DSRC_OFS_STATUS, 32'h0);
		n = m;
		tmo(100);
		apb(1'b0, DSRC_OFS_DATA, 32'h0);
		chk(rd_q, 32'hff);
		ext_read_gate <= 1'b0;
		spin <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk(pll_ref_lock, 32'h1);
		$display("test separator done");
		summarize();
	end
endmodule : testbench
